/* spi_flash_params.svh */
// Purpose: constants of the serial flash command block
// Assumes: 10 MHz system clock
// Notes:   codes, status field layout and timing counts
`ifndef SPI_FLASH_PARAMS_SVH
`define SPI_FLASH_PARAMS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define OP_WRITE_ENABLE    8'h06
`define OP_WRITE_DISABLE   8'h04
`define OP_VOLATILE_ENABLE 8'h50
`define OP_READ_STATUS1    8'h05
`define OP_READ_STATUS2    8'h35
`define OP_READ_STATUS3    8'h15
`define OP_WRITE_STATUS1   8'h01
`define OP_WRITE_STATUS2   8'h31
`define OP_WRITE_STATUS3   8'h11
`define OP_ENTER_ADDR4     8'hB7
`define OP_EXIT_ADDR4      8'hE9
`define OP_READ            8'h03
`define OP_READ_ADDR4      8'h13
`define OP_FAST_READ       8'h0B

// ----------------------------------------------------------------
// status field layout
// ----------------------------------------------------------------
`define SR1_BUSY_POS       0
`define SR1_WEL_POS        1
`define SR3_ADDR_MODE_POS  0
`define SR3_ADP_POS        1
`define SR1_WRITE_MASK     8'h7C
`define SR2_WRITE_MASK     8'h7B
`define SR3_WRITE_MASK     8'h66
`define SR2_OTP_MASK       8'h39
`define STATUS_RESET       24'h000000
`define NO_DATA_BYTE       8'hFF

// ----------------------------------------------------------------
// frame lengths and timing
// ----------------------------------------------------------------
`define CMD_BITS           6'd8
`define ADDR3_BITS         6'd24
`define ADDR4_BITS         6'd32
`define DUMMY_BITS         6'd8
`define ADDR3_MASK         32'h00FFFFFF
`define CLK_PERIOD_NS      100
`define STATUS_WRITE_NS    15000000
`define FIFO_DEPTH         32

`endif

/* spi_flash_pkg.sv */
// Purpose: shared types of the serial flash command block
// Assumes: constants live in spi_flash_params.svh
// Notes:   types only
package spi_flash_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_SIMPLE,
    ST_ADDR,
    ST_DUMMY,
    ST_WRS,
    ST_STAT_OUT,
    ST_READ_OUT
  } link_state_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } link_pins_t;

  typedef struct packed {
    logic [7:0] sr3;
    logic [7:0] sr2;
    logic [7:0] sr1;
  } status_bank_t;

endpackage : spi_flash_pkg

/* spi_flash_cmds.sv */
// Purpose: command handling of a serial flash: latch, status, address mode, reads
// Assumes: link pins are asynchronous and sampled by clk_i; array answers in order
// Notes:   array bytes pass a FIFO on their way to the serial output
`timescale 1ns/10ps
`include "spi_flash_params.svh"
`default_nettype none

// ----------------------------------------------------------------
// byte FIFO between array and serial output
// ----------------------------------------------------------------
module spi_flash_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             flush_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             in_ready_o,
  // drain side
  output var  logic             out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wptr;
  logic [PW-1:0]    next_rptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign push       = in_valid_i & in_ready_o & ~flush_i;
  assign pop        = out_valid_o & out_ready_i & ~flush_i;
  assign out_data_o = mem[rptr];

  always_comb begin
    next_wptr  = wptr;
    next_rptr  = rptr;
    next_count = count;
    if (flush_i) begin
      next_wptr  = '0;
      next_rptr  = '0;
      next_count = '0;
    end else begin
      if (push) begin
        next_wptr = (wptr == PW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        next_rptr = (rptr == PW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      next_count = count + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wptr        <= '0;
      rptr        <= '0;
      count       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      wptr        <= next_wptr;
      rptr        <= next_rptr;
      count       <= next_count;
      in_ready_o  <= (next_count != CW'(DEPTH));
      out_valid_o <= (next_count != '0);
    end
  end

  genvar e;
  generate
    for (e = 0; e < DEPTH; e++) begin : g_entry
      always_ff @(posedge clk_i) begin
        if (push && (wptr == PW'(e))) begin
          mem[e] <= in_data_i;
        end
      end
    end
  endgenerate
endmodule : spi_flash_fifo

// ----------------------------------------------------------------
// command sequencer
// ----------------------------------------------------------------
module spi_flash_cmds
  import spi_flash_pkg::*;
#(
  parameter int           STATUS_WRITE_NS = `STATUS_WRITE_NS,
  parameter status_bank_t NV_RESET        = `STATUS_RESET,
  parameter int           FIFO_DEPTH      = `FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // serial link pins
  input  wire logic         spi_cs_n_i,
  input  wire logic         spi_clk_i,
  input  wire logic         serial_in_pin_i,
  output var  logic         serial_out_o,
  output var  logic         serial_out_oe_o,
  // mode and reset
  input  wire logic         wide_mode_i,
  input  wire logic         soft_reset_i,
  // array fetch requests
  output var  logic         fetch_valid_o,
  output var  logic [31:0]  fetch_addr_o,
  input  wire logic         fetch_ready_i,
  output var  logic         fetch_abort_o,
  // array data
  input  wire logic         array_valid_i,
  input  wire logic [7:0]   array_data_i,
  output var  logic         array_ready_o,
  // status view
  output var  status_bank_t status_o,
  output var  logic         busy_o,
  output var  logic         write_latch_flag_o,
  output var  logic         addr4_mode_o
);
  localparam int WRITE_CYCLES_I = (STATUS_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [31:0] WRITE_CYCLES = (WRITE_CYCLES_I < 1) ? 32'd1 : 32'(WRITE_CYCLES_I);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  link_pins_t pin_s1;
  link_pins_t pin_s2;
  link_pins_t pin_prev;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1   <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
      pin_s2   <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
      pin_prev <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
    end else begin
      pin_s1   <= '{cs_n: spi_cs_n_i, sclk: spi_clk_i, mosi: serial_in_pin_i};
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  assign sclk_rise = ~pin_s2.cs_n & pin_s2.sclk & ~pin_prev.sclk;
  assign sclk_fall = ~pin_s2.cs_n & ~pin_s2.sclk & pin_prev.sclk;
  assign cs_rise   = pin_s2.cs_n & ~pin_prev.cs_n;

  // ----------------------------------------------------------------
  // status state
  // ----------------------------------------------------------------
  status_bank_t live;
  status_bank_t nv;
  logic         busy;
  logic         write_latch_flag;
  logic         vol_arm;
  logic         addr4;
  logic [31:0]  busy_cnt;
  logic [7:0]   status_view [3];

  assign status_view[0] = {live.sr1[7:2], write_latch_flag, busy};
  assign status_view[1] = live.sr2;
  assign status_view[2] = {live.sr3[7:1], addr4};

  // ----------------------------------------------------------------
  // link state
  // ----------------------------------------------------------------
  link_state_t state;
  logic [5:0]  bit_cnt;
  logic [31:0] shift_in;
  logic [7:0]  cmd;
  logic [1:0]  byte_cnt;
  logic [15:0] wr_data;
  logic [7:0]  out_sh;
  logic [2:0]  out_bits;
  logic [1:0]  stat_sel;
  logic        long_addr;
  logic        fast_rd;
  logic        ignore;
  logic        fifo_valid;
  logic [7:0]  fifo_data;

  link_state_t next_state;
  logic [5:0]  next_bit_cnt;
  logic [31:0] next_shift_in;
  logic [7:0]  next_cmd;
  logic [1:0]  next_byte_cnt;
  logic [15:0] next_wr_data;
  logic [7:0]  next_out_sh;
  logic [2:0]  next_out_bits;
  logic [1:0]  next_stat_sel;
  logic        next_long_addr;
  logic        next_fast_rd;
  logic        next_ignore;
  logic        next_so;
  logic        next_so_oe;
  logic        next_fetch_valid;
  logic [31:0] next_fetch_addr;
  logic        next_abort;
  logic        pop;
  logic        ev_decode;
  logic        ev_simple;
  logic        ev_wrs;
  logic [7:0]  code;
  logic [7:0]  obyte;

  always_comb begin
    next_state       = state;
    next_bit_cnt     = bit_cnt;
    next_shift_in    = shift_in;
    next_cmd         = cmd;
    next_byte_cnt    = byte_cnt;
    next_wr_data     = wr_data;
    next_out_sh      = out_sh;
    next_out_bits    = out_bits;
    next_stat_sel    = stat_sel;
    next_long_addr   = long_addr;
    next_fast_rd     = fast_rd;
    next_ignore      = ignore;
    next_so          = serial_out_o;
    next_so_oe       = serial_out_oe_o;
    next_fetch_valid = fetch_valid_o;
    next_fetch_addr  = fetch_addr_o;
    next_abort       = 1'b0;
    pop              = 1'b0;
    ev_decode        = 1'b0;
    ev_simple        = 1'b0;
    ev_wrs           = 1'b0;
    code             = {shift_in[6:0], pin_s2.mosi};
    obyte            = 8'h00;
    if (pin_s2.cs_n) begin
      if (cs_rise) begin
        ev_simple  = (state == ST_SIMPLE) && !ignore;
        ev_wrs     = (state == ST_WRS) && !ignore && (byte_cnt != 2'd0);
        next_abort = 1'b1;
      end
      next_state       = ST_IDLE;
      next_bit_cnt     = '0;
      next_byte_cnt    = '0;
      next_out_bits    = '0;
      next_ignore      = 1'b0;
      next_so_oe       = 1'b0;
      next_fetch_valid = 1'b0;
    end else begin
      if (state == ST_IDLE) begin
        next_state = ST_CMD;
      end
      if (sclk_rise && !ignore) begin
        next_shift_in = {shift_in[30:0], pin_s2.mosi};
        next_bit_cnt  = bit_cnt + 6'd1;
        unique case (state)
          ST_IDLE, ST_CMD: begin
            if (bit_cnt == `CMD_BITS - 6'd1) begin
              next_cmd     = code;
              next_bit_cnt = '0;
              ev_decode    = 1'b1;
              next_ignore  = busy;
              next_state   = ST_SIMPLE;
              unique case (code)
                `OP_READ_STATUS1, `OP_READ_STATUS2, `OP_READ_STATUS3: begin
                  next_ignore   = 1'b0;
                  next_state    = ST_STAT_OUT;
                  next_stat_sel = (code == `OP_READ_STATUS1) ? 2'd0 :
                                  (code == `OP_READ_STATUS2) ? 2'd1 : 2'd2;
                end
                `OP_WRITE_ENABLE, `OP_WRITE_DISABLE, `OP_VOLATILE_ENABLE,
                `OP_ENTER_ADDR4, `OP_EXIT_ADDR4: begin
                  next_state = ST_SIMPLE;
                end
                `OP_WRITE_STATUS1, `OP_WRITE_STATUS2, `OP_WRITE_STATUS3: begin
                  next_state = ST_WRS;
                end
                `OP_READ, `OP_READ_ADDR4, `OP_FAST_READ: begin
                  next_ignore    = busy | wide_mode_i;
                  next_state     = ST_ADDR;
                  next_long_addr = addr4 | (code == `OP_READ_ADDR4);
                  next_fast_rd   = (code == `OP_FAST_READ);
                end
                default: begin
                  next_ignore = 1'b1;
                end
              endcase
            end
          end
          ST_SIMPLE: begin
            next_ignore = 1'b1;
          end
          ST_ADDR: begin
            if (bit_cnt == (long_addr ? `ADDR4_BITS : `ADDR3_BITS) - 6'd1) begin
              next_fetch_addr  = long_addr ? next_shift_in : (next_shift_in & `ADDR3_MASK);
              next_fetch_valid = 1'b1;
              next_bit_cnt     = '0;
              next_out_bits    = '0;
              next_state       = fast_rd ? ST_DUMMY : ST_READ_OUT;
            end
          end
          ST_DUMMY: begin
            if (bit_cnt == `DUMMY_BITS - 6'd1) begin
              next_state = ST_READ_OUT;
            end
          end
          ST_WRS: begin
            if (bit_cnt[2:0] == 3'd7) begin
              if (byte_cnt == 2'd0) begin
                next_wr_data[7:0] = next_shift_in[7:0];
                next_byte_cnt     = 2'd1;
              end else if (byte_cnt == 2'd1 && cmd == `OP_WRITE_STATUS1) begin
                next_wr_data[15:8] = next_shift_in[7:0];
                next_byte_cnt      = 2'd2;
              end
            end
          end
          ST_STAT_OUT, ST_READ_OUT: begin
          end
        endcase
      end
      if (sclk_fall && !ignore && (state == ST_STAT_OUT || state == ST_READ_OUT)) begin
        if (out_bits == 3'd0) begin
          if (state == ST_STAT_OUT) begin
            obyte = status_view[stat_sel];
          end else begin
            obyte = fifo_valid ? fifo_data : `NO_DATA_BYTE;
            pop   = fifo_valid;
          end
        end else begin
          obyte = out_sh;
        end
        next_so       = obyte[7];
        next_out_sh   = {obyte[6:0], 1'b0};
        next_out_bits = out_bits + 3'd1;
        next_so_oe    = 1'b1;
      end
      if (fetch_valid_o && fetch_ready_i) begin
        next_fetch_addr = fetch_addr_o + 32'd1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state           <= ST_IDLE;
      bit_cnt         <= '0;
      shift_in        <= '0;
      cmd             <= 8'h00;
      byte_cnt        <= '0;
      wr_data         <= 16'h0000;
      out_sh          <= 8'h00;
      out_bits        <= '0;
      stat_sel        <= '0;
      long_addr       <= 1'b0;
      fast_rd         <= 1'b0;
      ignore          <= 1'b0;
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
      fetch_valid_o   <= 1'b0;
      fetch_addr_o    <= 32'h00000000;
      fetch_abort_o   <= 1'b0;
    end else begin
      state           <= next_state;
      bit_cnt         <= next_bit_cnt;
      shift_in        <= next_shift_in;
      cmd             <= next_cmd;
      byte_cnt        <= next_byte_cnt;
      wr_data         <= next_wr_data;
      out_sh          <= next_out_sh;
      out_bits        <= next_out_bits;
      stat_sel        <= next_stat_sel;
      long_addr       <= next_long_addr;
      fast_rd         <= next_fast_rd;
      ignore          <= next_ignore;
      serial_out_o    <= next_so;
      serial_out_oe_o <= next_so_oe;
      fetch_valid_o   <= next_fetch_valid;
      fetch_addr_o    <= next_fetch_addr;
      fetch_abort_o   <= next_abort;
    end
  end

  // ----------------------------------------------------------------
  // status registers, latch and timed write
  // ----------------------------------------------------------------
  status_bank_t next_live;
  status_bank_t next_nv;
  status_bank_t wr_bank;
  logic         next_busy;
  logic         next_wel;
  logic         next_vol_arm;
  logic         next_addr4;
  logic [31:0]  next_busy_cnt;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                       input logic [7:0] mask, input logic [7:0] otp);
    merge = (old & ~mask) | (data & mask) | (old & otp);
  endfunction

  always_comb begin
    next_live     = live;
    next_nv       = nv;
    next_busy     = busy;
    next_wel      = write_latch_flag;
    next_vol_arm  = vol_arm;
    next_addr4    = addr4;
    next_busy_cnt = busy_cnt;
    wr_bank       = write_latch_flag ? nv : live;
    unique case (cmd)
      `OP_WRITE_STATUS2: begin
        wr_bank.sr2 = merge(wr_bank.sr2, wr_data[7:0], `SR2_WRITE_MASK, `SR2_OTP_MASK);
      end
      `OP_WRITE_STATUS3: begin
        wr_bank.sr3 = merge(wr_bank.sr3, wr_data[7:0], `SR3_WRITE_MASK, 8'h00);
      end
      default: begin
        wr_bank.sr1 = merge(wr_bank.sr1, wr_data[7:0], `SR1_WRITE_MASK, 8'h00);
        if (byte_cnt == 2'd2) begin
          wr_bank.sr2 = merge(wr_bank.sr2, wr_data[15:8], `SR2_WRITE_MASK, `SR2_OTP_MASK);
        end
      end
    endcase
    if (busy) begin
      next_busy_cnt = busy_cnt - 32'd1;
      if (busy_cnt == 32'd1) begin
        next_busy = 1'b0;
        next_wel  = 1'b0;
      end
    end
    if (soft_reset_i) begin
      next_live    = nv;
      next_wel     = 1'b0;
      next_vol_arm = 1'b0;
      next_addr4   = nv.sr3[`SR3_ADP_POS];
    end else begin
      if (ev_decode && !(next_cmd == `OP_WRITE_STATUS1 || next_cmd == `OP_WRITE_STATUS2 ||
                         next_cmd == `OP_WRITE_STATUS3)) begin
        next_vol_arm = 1'b0;
      end
      if (ev_simple) begin
        unique case (cmd)
          `OP_WRITE_ENABLE:    next_wel     = 1'b1;
          `OP_WRITE_DISABLE:   next_wel     = 1'b0;
          `OP_VOLATILE_ENABLE: next_vol_arm = 1'b1;
          `OP_ENTER_ADDR4:     next_addr4   = 1'b1;
          `OP_EXIT_ADDR4:      next_addr4   = 1'b0;
          default: begin
          end
        endcase
      end
      if (ev_wrs) begin
        next_vol_arm = 1'b0;
        if (write_latch_flag) begin
          next_nv       = wr_bank;
          next_busy     = 1'b1;
          next_busy_cnt = WRITE_CYCLES;
          // only the registers this write names follow the new copy; live locks stay set
          unique case (cmd)
            `OP_WRITE_STATUS2: begin
              next_live.sr2 = wr_bank.sr2 | (live.sr2 & `SR2_OTP_MASK);
            end
            `OP_WRITE_STATUS3: begin
              next_live.sr3 = wr_bank.sr3;
            end
            default: begin
              next_live.sr1 = wr_bank.sr1;
              if (byte_cnt == 2'd2) begin
                next_live.sr2 = wr_bank.sr2 | (live.sr2 & `SR2_OTP_MASK);
              end
            end
          endcase
        end else if (vol_arm) begin
          next_live = wr_bank;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      live     <= NV_RESET;
      nv       <= NV_RESET;
      busy     <= 1'b0;
      write_latch_flag      <= 1'b0;
      vol_arm  <= 1'b0;
      addr4    <= NV_RESET.sr3[`SR3_ADP_POS];
      busy_cnt <= 32'h00000000;
    end else begin
      live     <= next_live;
      nv       <= next_nv;
      busy     <= next_busy;
      write_latch_flag      <= next_wel;
      vol_arm  <= next_vol_arm;
      addr4    <= next_addr4;
      busy_cnt <= next_busy_cnt;
    end
  end

  // ----------------------------------------------------------------
  // status view outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_o           <= '{sr3: {NV_RESET.sr3[7:1], NV_RESET.sr3[`SR3_ADP_POS]},
                              sr2: NV_RESET.sr2,
                              sr1: {NV_RESET.sr1[7:2], 2'b00}};
      busy_o             <= 1'b0;
      write_latch_flag_o <= 1'b0;
      addr4_mode_o       <= NV_RESET.sr3[`SR3_ADP_POS];
    end else begin
      status_o           <= '{sr3: status_view[2], sr2: status_view[1], sr1: status_view[0]};
      busy_o             <= busy;
      write_latch_flag_o <= write_latch_flag;
      addr4_mode_o       <= addr4;
    end
  end

  // ----------------------------------------------------------------
  // array data buffer
  // ----------------------------------------------------------------
  spi_flash_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .flush_i     (fetch_abort_o),
    .in_valid_i  (array_valid_i),
    .in_data_i   (array_data_i),
    .in_ready_o  (array_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (pop)
  );
endmodule : spi_flash_cmds

`default_nettype wire

/* spi_flash_cmds_chk.sv */
// Purpose: port checks of the command block
// Assumes: link clock far slower than clk_i
// Notes: bound below
`timescale 1ns/10ps
`default_nettype none
module spi_flash_cmds_chk
  import spi_flash_pkg::*;
(
  // observed ports
  input wire logic         clk_i,
  input wire logic         nrst_i,
  input wire logic         spi_cs_n_i,
  input wire logic         wide_mode_i,
  input wire logic         soft_reset_i,
  input wire logic         serial_out_oe_o,
  input wire logic         fetch_valid_o,
  input wire logic [31:0]  fetch_addr_o,
  input wire logic         fetch_ready_i,
  input wire logic         fetch_abort_o,
  input wire status_bank_t status_o,
  input wire logic         busy_o,
  input wire logic         write_latch_flag_o,
  input wire logic         addr4_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_oe_idle: assert property (spi_cs_n_i [*6] |-> !serial_out_oe_o)
    else $error("output driven while deselected");
  a_busy_nofetch: assert property (busy_o |-> !fetch_valid_o)
    else $error("fetch while busy");
  a_wide_nofetch: assert property ($rose(fetch_valid_o) |-> !wide_mode_i)
    else $error("fetch in wide mode");
  a_flag_view: assert property (write_latch_flag_o == status_o.sr1[1] && busy_o == status_o.sr1[0])
    else $error("flags differ from status view");
  a_addr_view: assert property (addr4_mode_o == status_o.sr3[0])
    else $error("address mode differs from status view");
  a_busy_end: assert property ($fell(busy_o) |-> !write_latch_flag_o)
    else $error("latch left set after write cycle");
  a_lock_sticky: assert property (!$past(soft_reset_i) |=> (($past(status_o.sr2) & ~status_o.sr2) & 8'h39) == 8'h00)
    else $error("lock bit cleared");
  a_abort_once: assert property (fetch_abort_o |=> !fetch_abort_o && !fetch_valid_o)
    else $error("abort not a single pulse");
  a_addr_step: assert property (fetch_valid_o && fetch_ready_i |=>
    !fetch_valid_o || fetch_addr_o == $past(fetch_addr_o) + 32'h1)
    else $error("fetch address did not step");
  c_fetch: cover property (fetch_valid_o && fetch_ready_i);
  c_busy: cover property ($fell(busy_o));
  c_abort: cover property (fetch_abort_o);
endmodule : spi_flash_cmds_chk
bind spi_flash_cmds spi_flash_cmds_chk chk_u (.clk_i, .nrst_i, .spi_cs_n_i, .wide_mode_i, .soft_reset_i,
  .serial_out_oe_o, .fetch_valid_o, .fetch_addr_o, .fetch_ready_i, .fetch_abort_o, .status_o, .busy_o,
  .write_latch_flag_o, .addr4_mode_o);
`default_nettype wire

/* spi_host_model.sv */
// Purpose: host side of the serial link, mode 0, 800 ns bit time
// Assumes: tasks called from one process
// Notes: clock low 300 ns, high 500 ns, input sampled late in high phase
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // clock
  input  wire logic clk_i,
  // link pins
  output var  logic spi_cs_n_o,
  output var  logic spi_clk_o,
  output var  logic serial_in_pin_o,
  input  wire logic serial_out_i
);
  initial begin
    spi_cs_n_o = 1'b1;
    spi_clk_o = 1'b0;
    serial_in_pin_o = 1'b0;
  end
  task automatic sel;
    @(posedge clk_i);
    #1 spi_cs_n_o = 1'b0;
    #400;
  endtask : sel
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_clk_o = 1'b0;
      serial_in_pin_o = tx[i];
      #300 spi_clk_o = 1'b1;
      #490 rx[i] = serial_out_i;
      #10;
    end
  endtask : xfer
  task automatic desel;
    spi_clk_o = 1'b0;
    #300 spi_cs_n_o = 1'b1;
    serial_in_pin_o = ~serial_in_pin_o;
    #800;
  endtask : desel
endmodule : spi_host_model
`default_nettype wire

/* spi_flash_cmds_test.sv */
// Purpose: self-checking bench of the command block
// Assumes: array byte is address low byte xor 5A
// Notes: status write cycle shortened to 1000 clocks
`timescale 1ns/10ps
`default_nettype none
module spi_flash_cmds_test;
  import spi_flash_pkg::*;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
  logic clk_i = 1'b0, nrst_i = 1'b0, wide_mode_i = 1'b0, soft_reset_i = 1'b0;
  logic array_valid_i = 1'b0, full_seen = 1'b0;
  logic [7:0] array_data_i = 8'h00, rx;
  logic cs_n, sck, sin, sout, oe, fv, fab, ar, busy, write_latch_flag, a4;
  logic [31:0] fa;
  status_bank_t st;
  int checks = 0, bad_count = 0, fetch_count = 0, n;
  always #50 clk_i = ~clk_i;
  // released output floats to its pull-up
  spi_host_model h (.clk_i(clk_i), .spi_cs_n_o(cs_n), .spi_clk_o(sck), .serial_in_pin_o(sin),
    .serial_out_i(oe ? sout : 1'b1));
  spi_flash_cmds #(.STATUS_WRITE_NS(100000)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .spi_cs_n_i(cs_n),
    .spi_clk_i(sck), .serial_in_pin_i(sin), .serial_out_o(sout), .serial_out_oe_o(oe), .wide_mode_i(wide_mode_i),
    .soft_reset_i(soft_reset_i), .fetch_valid_o(fv), .fetch_addr_o(fa), .fetch_ready_i(ar), .fetch_abort_o(fab),
    .array_valid_i(array_valid_i), .array_data_i(array_data_i), .array_ready_o(ar), .status_o(st),
    .busy_o(busy), .write_latch_flag_o(write_latch_flag), .addr4_mode_o(a4));
  // array answers one cycle after each accepted request, holds while stalled
  always @(posedge clk_i) begin
    if (!ar) full_seen <= 1'b1;
    if (fab) array_valid_i <= 1'b0;
    else if (!array_valid_i || ar) begin
      array_valid_i <= fv && ar;
      array_data_i <= fa[7:0] ^ 8'h5A;
      if (fv && ar) fetch_count <= fetch_count + 1;
    end
  end
  task automatic cmd(input logic [7:0] op);
    h.sel;
    h.xfer(op, rx);
    h.desel;
  endtask : cmd
  task automatic wrs(input logic [7:0] op, input logic [15:0] d, input int nb);
    h.sel;
    h.xfer(op, rx);
    for (int i = 0; i < nb; i++) h.xfer(d[15-8*i -: 8], rx);
    h.desel;
  endtask : wrs
  task automatic rdsr(input logic [7:0] op, input logic [7:0] e);
    h.sel;
    h.xfer(op, rx);
    repeat (2) begin
      h.xfer(8'h00, rx);
      `CHK(rx, e)
    end
    h.desel;
  endtask : rdsr
  task automatic rd(input logic [7:0] op, input int na, input logic [31:0] a, input int nd, input int nb);
    h.sel;
    h.xfer(op, rx);
    for (int i = na - 1; i >= 0; i--) h.xfer(a[8*i +: 8], rx);
    repeat (nd) h.xfer(8'h00, rx);
    for (int i = 0; i < nb; i++) begin
      h.xfer(8'h00, rx);
      `CHK(rx, (a[7:0] + 8'(i)) ^ 8'h5A)
    end
    h.desel;
  endtask : rd
  task automatic wait_idle;
    for (int i = 0; i < 1200 && busy !== 1'b0; i++) @(posedge clk_i);
    `CHK(busy, 1'b0)
  endtask : wait_idle
  task automatic final_report;
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #3000000;
    bad_count++;
    final_report;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    `CHK(write_latch_flag, 1'b0)
    rdsr(8'h05, 8'h00);
    cmd(8'h06);
    `CHK(write_latch_flag, 1'b1)
    rdsr(8'h05, 8'h02);
    cmd(8'h04);
    `CHK(write_latch_flag, 1'b0)
    cmd(8'h50);
    wrs(8'h01, 16'hFF00, 1);
    `CHK({busy, write_latch_flag, st.sr1}, 10'h07C)
    @(posedge clk_i);
    #1 soft_reset_i = 1'b1;
    @(posedge clk_i);
    #1 soft_reset_i = 1'b0;
    @(posedge clk_i);
    #1;
    `CHK(st.sr1, 8'h00)
    cmd(8'h50);
    cmd(8'h04);
    wrs(8'h01, 16'h0C00, 1);
    `CHK(st.sr1, 8'h00)
    cmd(8'h06);
    wrs(8'h01, 16'h3C78, 2);
    rdsr(8'h05, 8'h3F);
    n = fetch_count;
    rd(8'h03, 3, 32'h0, 0, 0);
    `CHK(fetch_count, n)
    wait_idle;
    `CHK({write_latch_flag, st.sr2}, 9'h078)
    cmd(8'h50);
    wrs(8'h31, 16'h0000, 1);
    `CHK(st.sr2, 8'h38)
    rdsr(8'h35, 8'h38);
    cmd(8'h06);
    wrs(8'h01, 16'h0400, 1);
    wait_idle;
    `CHK({st.sr2, st.sr1}, 16'h3804)
    cmd(8'hB7);
    `CHK(a4, 1'b1)
    rd(8'h03, 4, 32'h000000FE, 0, 3);
    cmd(8'hE9);
    `CHK(a4, 1'b0)
    rd(8'h03, 3, 32'h0000FE, 0, 3);
    `CHK({full_seen, ar, oe}, 3'b110)
    rd(8'h13, 4, 32'h01000010, 0, 2);
    rd(8'h0B, 3, 32'h000033, 1, 2);
    cmd(8'h50);
    wrs(8'h11, 16'hFF00, 1);
    rdsr(8'h15, 8'h66);
    @(posedge clk_i);
    #1 wide_mode_i = 1'b1;
    n = fetch_count;
    rd(8'h03, 3, 32'h0, 0, 0);
    `CHK(fetch_count, n)
    final_report;
  end
endmodule : spi_flash_cmds_test
`default_nettype wire
